// >>> ddsw_ctrl_model.sv
// Memory controller model: drives the DRAM command pins for mode writes and self refresh.
// Assumes the bench calls its tasks one at a time and keeps hclk steady throughout.
`timescale 1ns/100ps
`default_nettype none
module ddsw_ctrl_model #(
    parameter int ADDR_W = 18,
    parameter int HOLD   = 4,
    parameter int GAP    = 4
) (
    // Clock.
    input  wire logic              hclk,
    // Command pins.
    output logic                   cke,
    output logic                   cs_n,
    output logic                   act_n,
    output logic                   ras_n,
    output logic                   cas_n,
    output logic                   we_n,
    output logic [2:0]             mr_sel,
    output logic [ADDR_W-1:0]      addr
);
    // Power up with clock enable low and the device deselected.
    initial begin
        cke = 1'b0;
        {cs_n, act_n, ras_n, cas_n, we_n} = 5'b11111;
        mr_sel = 3'h0;
        addr = '0;
    end

    // Each command is held HOLD cycles because the device synchronises the pins.
    // A released address bus shows the inverse of its last value, so nothing stale is read.
    task automatic drive(input logic c, input logic [4:0] p, input logic [2:0] s,
                         input logic [ADDR_W-1:0] a);
        @(posedge hclk);
        cke <= c;
        {cs_n, act_n, ras_n, cas_n, we_n} <= p;
        mr_sel <= s;
        addr <= a;
        repeat (HOLD) @(posedge hclk);
        {cs_n, act_n, ras_n, cas_n, we_n} <= 5'b11111;
        addr <= ~a;
        repeat (GAP) @(posedge hclk);
    endtask : drive

    // Mode write from idle with CKE high; the clock is never changed outside self refresh.
    task automatic mrs(input logic [2:0] s, input logic [ADDR_W-1:0] a);
        drive(1'b1, 5'b01000, s, a);
    endtask : mrs

    // Clock enable rises with the device deselected.
    task automatic power_up();
        drive(1'b1, 5'b11111, 3'h0, '0);
    endtask : power_up

    // Extra refresh between two self refresh periods.
    task automatic refresh();
        drive(1'b1, 5'b01001, 3'h0, '0);
    endtask : refresh

    // Self refresh entry from idle.
    task automatic sre();
        drive(1'b0, 5'b01001, 3'h0, '0);
    endtask : sre

    // Exit on a stable clock with deselect; CKE then stays high until the next entry.
    task automatic srx();
        drive(1'b1, 5'b11111, 3'h0, '0);
    endtask : srx
endmodule : ddsw_ctrl_model
`default_nettype wire

// >>> ddsw_pkg.sv
// Constants, field positions and state codes for the DLL switch and clock change logic.
// Assumes a single 100 MHz clock domain and a 32-bit AHB-Lite register port.
package ddsw_pkg;

    // Clock rate and conversion of a least time in ns to whole cycles, never below one.
    localparam int CLK_MHZ = 100;
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    // Default waits as times, then as cycle counts.
    localparam int SR_ENTRY_HOLD_NS = 10;
    localparam int SR_EXIT_NS       = 180;
    localparam int SR_ABORT_NS      = 120;
    localparam int DLL_LOCK_NS      = 5000;
    localparam int REF_INTERVAL_NS  = 7800;
    localparam int REF_BUSY_NS      = 350;
    localparam int SR_ENTRY_HOLD_CYC = ns_to_cyc(SR_ENTRY_HOLD_NS);
    localparam int SR_EXIT_CYC       = ns_to_cyc(SR_EXIT_NS);
    localparam int SR_ABORT_CYC      = ns_to_cyc(SR_ABORT_NS);
    localparam int DLL_LOCK_CYC      = ns_to_cyc(DLL_LOCK_NS);
    localparam int REF_INTERVAL_CYC  = ns_to_cyc(REF_INTERVAL_NS);
    localparam int REF_BUSY_CYC      = ns_to_cyc(REF_BUSY_NS);

    // Register byte offsets.
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_TIM0   = 8'h04;
    localparam logic [7:0] REG_TIM1   = 8'h08;
    localparam logic [7:0] REG_TIM2   = 8'h0C;
    localparam logic [7:0] REG_REFCNT = 8'h10;

    // Status register bit positions.
    localparam int ST_DLL_EN   = 0;
    localparam int ST_LOCKED   = 1;
    localparam int ST_IN_SR    = 2;
    localparam int ST_CLK_FREE = 3;
    localparam int ST_READY    = 4;
    localparam int ST_LAT_OK   = 5;
    localparam int ST_ABORTED  = 6;

    // Mode register numbers and bit positions.
    localparam logic [2:0] MR_ZERO  = 3'h0;
    localparam logic [2:0] MR_ONE   = 3'h1;
    localparam logic [2:0] MR_TWO   = 3'h2;
    localparam logic [2:0] MR_FOUR  = 3'h4;
    localparam logic [2:0] MR_SIX   = 3'h6;
    localparam int DLL_ENABLE_BIT   = 0;
    localparam int DLL_RESET_BIT    = 8;
    localparam int SR_ABORT_BIT     = 9;

    // Latency codes for the only pair needed with the DLL off (read 10, write 9).
    localparam logic [3:0] RL_CAS_10_CODE = 4'h1;
    localparam logic [2:0] WL_CAS_9_CODE  = 3'h0;

    // One-hot sequencer states.
    typedef enum logic [3:0] {
        S_IDLE    = 4'b0001,
        S_SR_HOLD = 4'b0010,
        S_SR      = 4'b0100,
        S_EXIT    = 4'b1000
    } ddsw_state_t;

endpackage : ddsw_pkg

// >>> ddsw_tb_top.sv
// Self-checking bench for the DLL switch block: AHB-Lite master plus controller model.
// Assumes the designer's latencies: zero-wait bus, outputs 4 cycles behind the pins.
`timescale 1ns/100ps
`default_nettype none
module ddsw_tb_top;
    // Bus side, all driven from time zero.
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, cke, cs_n, act_n, ras_n, cas_n, we_n;
    logic [2:0]  mr_sel;
    logic [17:0] addr;
    logic        dll_enabled, dll_locked, in_self_refresh, clock_free, cmd_ready;
    int          num_errors = 0, samples_checked = 0, n;

    // Free-running 100 MHz clock.
    always #5 hclk = ~hclk;

    ddsw_top u_ddsw_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cke(cke), .cs_n(cs_n),
        .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mr_sel(mr_sel),
        .addr(addr), .dll_enabled(dll_enabled), .dll_locked(dll_locked),
        .in_self_refresh(in_self_refresh), .clock_free(clock_free), .cmd_ready(cmd_ready));
    ddsw_ctrl_model u_ddsw_ctrl_model (.hclk(hclk), .cke(cke), .cs_n(cs_n), .act_n(act_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mr_sel(mr_sel), .addr(addr));

    // Verdict and end of run, also reached from any wait that runs out.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic chk1(input string what, input logic seen, input logic exp);
        check(what, {31'h0, seen}, {31'h0, exp});
    endtask : chk1

    function automatic logic sig(input int w);
        case (w)
            0: return dll_enabled;
            1: return dll_locked;
            2: return in_self_refresh;
            3: return clock_free;
            default: return cmd_ready;
        endcase
    endfunction : sig

    // Bounded wait for a status output; n counts the edges passed.
    task automatic wait_for(input int w, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (sig(w) !== v && cnt <= lim) begin
            @(posedge hclk);
            cnt++;
        end
        if (cnt > lim) begin
            num_errors++;
            $display("[ERR] status output %0d expected %b seen timeout", w, v);
            summarize();
        end
    endtask : wait_for

    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            $display("[ERR] hready expected 1 seen timeout");
            summarize();
        end
    endtask : wait_rdy

    // One single word transfer: address phase, then data phase, data taken at its end.
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0000_0000);
    endtask : ahb

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        ahb(1'b0, {24'h0, a}, 32'h0000_0000);
        check(what, rd & m, exp);
    endtask : rd_chk

    // One self refresh period: entry, clock released after the hold, exit wait measured.
    task automatic sr_cycle(input logic abort);
        u_ddsw_ctrl_model.sre();
        chk1("in_self_refresh", in_self_refresh, 1'b1);
        chk1("clock_free early", clock_free, 1'b0);
        wait_for(3, 1'b1, 40, n);
        chk1("clock_free after hold", (n + 8 >= 20) && (n + 8 <= 32), 1'b1);
        chk1("cmd_ready in refresh", cmd_ready, 1'b0);
        u_ddsw_ctrl_model.srx();
        wait_for(4, 1'b1, 60, n);
        chk1("exit wait", abort ? (n + 8 <= 14) : (n + 8 >= 20 && n + 8 <= 32), 1'b1);
    endtask : sr_cycle

    task automatic t_regs();
        logic [31:0] tv [3];
        tv = '{32'h0014_0014, 32'h0028_0004, 32'h00C8_0003};
        rd_chk("status after reset", ddsw_pkg::REG_STATUS, 32'h0000_005F, 32'h0000_0011);
        for (int i = 0; i < 3; i++) ahb(1'b1, 32'h0000_0004 + 32'(4 * i), tv[i]);
        for (int i = 0; i < 3; i++) rd_chk("timing", 8'h04 + 8'(4 * i), '1, tv[i]);
        ahb(1'b1, 32'h0000_0020, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h20, '1, 32'h0000_0000);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
        rd_chk("status read only", ddsw_pkg::REG_STATUS, 32'h0000_0011, 32'h0000_0011);
    endtask : t_regs

    task automatic t_dll_off();
        u_ddsw_ctrl_model.mrs(ddsw_pkg::MR_ONE, 18'h0_0000);
        wait_for(0, 1'b0, 10, n);
        chk1("dll off", dll_enabled, 1'b0);
        u_ddsw_ctrl_model.mrs(ddsw_pkg::MR_ZERO, 18'h0_0004);
        u_ddsw_ctrl_model.mrs(ddsw_pkg::MR_TWO, 18'h0_0000);
        rd_chk("latency pair", ddsw_pkg::REG_STATUS, 32'h0000_0020, 32'h0000_0020);
        u_ddsw_ctrl_model.mrs(ddsw_pkg::MR_ZERO, 18'h0_0010);
        rd_chk("latency other", ddsw_pkg::REG_STATUS, 32'h0000_0020, 32'h0000_0000);
        u_ddsw_ctrl_model.mrs(ddsw_pkg::MR_ZERO, 18'h0_0004);
        sr_cycle(1'b0);
        chk1("dll stays off", dll_enabled, 1'b0);
        // The one refresh begun in this period runs out after exit and must be counted.
        repeat (220) @(posedge hclk);
        rd_chk("refresh counted", ddsw_pkg::REG_REFCNT, '1, 32'h0000_0001);
    endtask : t_dll_off

    task automatic t_abort();
        logic [31:0] c0;
        u_ddsw_ctrl_model.refresh();
        u_ddsw_ctrl_model.mrs(ddsw_pkg::MR_FOUR, 18'h0_0200);
        ahb(1'b0, {24'h0, ddsw_pkg::REG_REFCNT}, 32'h0000_0000);
        c0 = rd;
        sr_cycle(1'b1);
        // A refresh that escaped the abort would finish and be counted within this wait.
        repeat (220) @(posedge hclk);
        rd_chk("refresh count", ddsw_pkg::REG_REFCNT, '1, c0);
        rd_chk("aborted", ddsw_pkg::REG_STATUS, 32'h0000_0040, 32'h0000_0040);
    endtask : t_abort

    task automatic t_dll_on();
        u_ddsw_ctrl_model.mrs(ddsw_pkg::MR_ONE, 18'h0_0001);
        wait_for(0, 1'b1, 10, n);
        chk1("dll on", dll_enabled, 1'b1);
        u_ddsw_ctrl_model.mrs(ddsw_pkg::MR_ZERO, 18'h0_0104);
        chk1("lock early", dll_locked, 1'b0);
        wait_for(1, 1'b1, 60, n);
        chk1("lock time", (n + 8 >= 40) && (n + 8 <= 52), 1'b1);
        u_ddsw_ctrl_model.mrs(ddsw_pkg::MR_SIX, 18'h0_0000);
        u_ddsw_ctrl_model.refresh();
        sr_cycle(1'b1);
        wait_for(1, 1'b1, 60, n);
        chk1("relock at exit", dll_locked, 1'b1);
    endtask : t_dll_on

    // Reset for five cycles, power up the pins, then run each scenario.
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        chk1("hreadyout", hreadyout, 1'b1);
        u_ddsw_ctrl_model.power_up();
        t_regs();
        t_dll_off();
        t_abort();
        t_dll_on();
        summarize();
    end
endmodule : ddsw_tb_top
`default_nettype wire

// >>> ddsw_top.sv
// DLL on/off switching and clock-change tracking inside the DRAM, with AHB-Lite status port.
// Assumes the command pins arrive from outside the hclk domain and are synchronised here.
//
// Functional notes
// [R01] Mode-one bit zero written 0 disables DLL.
// [R02] Controller idles, precharges, terminations off first.
// [R03] Controller waits mode delay, enters self refresh.
// [R04] Controller holds clock stable before self refresh exit.
// [R05] Controller holds CKE high through mode delay.
// [R06] Only calibration and latency writes after fast delay.
// [R07] Abort bit stops refresh, no count, short delay.
// [R08] Controller refreshes once more before reentering.
// [R09] Array commands wait full exit delay; with abort enabled, cmd_ready rises after the abort delay instead.
// [R10] DLL-on switch starts idle, changes clock in refresh.
// [R11] Controller holds CKE and termination until lock.
// [R12] Controller enables DLL, then resets it.
// [R13] Controller waits lock and calibration times.
// [R14] Clock changes only during self refresh.
// [R15] After entry hold, device ignores clock.
// [R16] Parity latency off before faster clock.
// [R17] Late latency updates finish before leaving idle.
// [R18] Lock-time write before entry relocks at exit.
// [R19] Frequency stays within speed grade limits.
// [R20] Controller reprograms latencies for new clock.
// [R21] DLL off supports read 10, write 9 only.
// [R22] Controller drives deselect during exit delay.
// [R23] Each wait is a programmable cycle counter.
`timescale 1ns/100ps
`default_nettype none
module ddsw_top #(
    parameter int ADDR_W = 18
) (
    // Clock and reset.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Command pins from the controller.
    input  wire logic              cke,
    input  wire logic              cs_n,
    input  wire logic              act_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [2:0]        mr_sel,
    input  wire logic [ADDR_W-1:0] addr,
    // Device state.
    output logic                   dll_enabled,
    output logic                   dll_locked,
    output logic                   in_self_refresh,
    output logic                   clock_free,
    output logic                   cmd_ready
);

    localparam int PW = ADDR_W + 9;

    // Two-flop synchroniser for the command pins; only the second stage is read.
    logic [PW-1:0] pin_s1_q;
    logic [PW-1:0] pin_s2_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {cke, cs_n, act_n, ras_n, cas_n, we_n, mr_sel, addr};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Decoded command fields and the previous clock enable level.
    logic              cke_prev_q;
    wire               p_cke  = pin_s2_q[PW-1];
    wire  [4:0]        p_cmd  = pin_s2_q[PW-2:PW-6];
    wire  [2:0]        p_mr   = pin_s2_q[ADDR_W+2:ADDR_W];
    wire  [ADDR_W-1:0] p_addr = pin_s2_q[ADDR_W-1:0];
    wire               cmd_mrs = p_cke && cke_prev_q && (p_cmd == 5'b01000);
    wire               cmd_sre = !p_cke && cke_prev_q && (p_cmd == 5'b01001);
    wire               cmd_srx = p_cke && !cke_prev_q;

    // Sequencer and counters.
    ddsw_pkg::ddsw_state_t state_q, state_d;
    logic [15:0] cnt_q;
    logic [15:0] lock_cnt_q;
    logic [15:0] ref_tmr_q;
    logic [15:0] ref_busy_q;
    logic [31:0] ref_count_q;
    logic        dll_en_q, locked_q, abort_en_q, mr6_new_q, aborted_q;
    logic [3:0]  rl_code_q;
    logic [2:0]  wl_code_q;
    // Programmable waits (entry hold, exit, abort, lock, refresh interval, refresh busy).
    logic [15:0] t_hold_q, t_exit_q, t_abort_q, t_lock_q, t_rint_q, t_rbusy_q;

    wire cnt_done   = (cnt_q == 16'h0000);
    wire ref_active = (ref_busy_q != 16'h0000);
    wire in_sr      = (state_q == ddsw_pkg::S_SR_HOLD) || (state_q == ddsw_pkg::S_SR);
    wire srx_ok     = cmd_srx && in_sr;
    // With the DLL off only the one latency pair is supported.
    wire lat_ok     = dll_en_q || ((rl_code_q == ddsw_pkg::RL_CAS_10_CODE)
                      && (wl_code_q == ddsw_pkg::WL_CAS_9_CODE)); // [R21]
    wire relock_go  = (cmd_mrs && (p_mr == ddsw_pkg::MR_ZERO)
                      && p_addr[ddsw_pkg::DLL_RESET_BIT])
                      || (srx_ok && mr6_new_q); // [R18]

    // Next-state logic: entry hold, self refresh, exit wait.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ddsw_pkg::S_IDLE:    if (cmd_sre) state_d = ddsw_pkg::S_SR_HOLD;
            ddsw_pkg::S_SR_HOLD: if (cmd_srx) state_d = ddsw_pkg::S_EXIT;
                                 else if (cnt_done) state_d = ddsw_pkg::S_SR;
            ddsw_pkg::S_SR:      if (cmd_srx) state_d = ddsw_pkg::S_EXIT;
            ddsw_pkg::S_EXIT:    if (cnt_done) state_d = ddsw_pkg::S_IDLE;
            default:             state_d = ddsw_pkg::S_IDLE;
        endcase
    end

    // State counter: loads entry hold on entry, exit or abort delay on exit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q    <= ddsw_pkg::S_IDLE;
            cnt_q      <= 16'h0000;
            cke_prev_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cke_prev_q <= p_cke;
            if (cmd_sre && state_q == ddsw_pkg::S_IDLE) begin
                cnt_q <= t_hold_q; // [R23]
            end else if (srx_ok) begin
                cnt_q <= abort_en_q ? t_abort_q : t_exit_q; // [R07]
            end else if (!cnt_done) begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    // Mode register shadows; the DLL enable bit is stored as written.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dll_en_q   <= 1'b1;
            abort_en_q <= 1'b0;
            mr6_new_q  <= 1'b0;
            rl_code_q  <= 4'h0;
            wl_code_q  <= 3'h0;
        end else begin
            if (cmd_mrs && p_mr == ddsw_pkg::MR_ONE) begin
                dll_en_q <= p_addr[ddsw_pkg::DLL_ENABLE_BIT]; // [R01]
            end
            if (cmd_mrs && p_mr == ddsw_pkg::MR_FOUR) begin
                abort_en_q <= p_addr[ddsw_pkg::SR_ABORT_BIT];
            end
            if (cmd_mrs && p_mr == ddsw_pkg::MR_ZERO) begin
                rl_code_q <= {p_addr[6:4], p_addr[2]};
            end
            if (cmd_mrs && p_mr == ddsw_pkg::MR_TWO) begin
                wl_code_q <= p_addr[5:3];
            end
            // A lock-time write before entry is consumed by the automatic relock at exit.
            if (cmd_mrs && p_mr == ddsw_pkg::MR_SIX && state_q == ddsw_pkg::S_IDLE) begin
                mr6_new_q <= 1'b1; // [R18]
            end else if (srx_ok) begin
                mr6_new_q <= 1'b0;
            end
        end
    end

    // DLL lock counter; a disable drops lock at once and a reset or relock restarts it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_cnt_q <= 16'h0000;
            locked_q   <= 1'b0;
        end else begin
            if (cmd_mrs && p_mr == ddsw_pkg::MR_ONE && !p_addr[ddsw_pkg::DLL_ENABLE_BIT]) begin
                locked_q   <= 1'b0; // [R01]
                lock_cnt_q <= 16'h0000;
            end else if (relock_go && dll_en_q) begin
                locked_q   <= 1'b0; // [R18]
                lock_cnt_q <= t_lock_q;
            end else if (lock_cnt_q != 16'h0000) begin
                lock_cnt_q <= lock_cnt_q - 16'h0001;
                locked_q   <= (lock_cnt_q == 16'h0001) && dll_en_q;
            end
        end
    end

    // Self refresh engine; an abort at exit drops the refresh without counting it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_tmr_q   <= 16'h0000;
            ref_busy_q  <= 16'h0000;
            ref_count_q <= 32'h0000_0000;
            aborted_q   <= 1'b0;
        end else begin
            if (srx_ok && abort_en_q && ref_active) begin
                ref_busy_q <= 16'h0000; // [R07]
                aborted_q  <= 1'b1;
            end else if (ref_active) begin
                ref_busy_q <= ref_busy_q - 16'h0001;
                if (ref_busy_q == 16'h0001) begin
                    ref_count_q <= ref_count_q + 32'h0000_0001;
                end
            end else if (in_sr && ref_tmr_q == 16'h0000) begin
                ref_busy_q <= t_rbusy_q;
            end
            if (cmd_sre) begin
                aborted_q <= 1'b0;
            end
            if (!in_sr || ref_tmr_q == 16'h0000) begin
                ref_tmr_q <= t_rint_q;
            end else begin
                ref_tmr_q <= ref_tmr_q - 16'h0001;
            end
        end
    end

    // Registered device state outputs; the clock is free only after the entry hold.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dll_enabled     <= 1'b1;
            dll_locked      <= 1'b0;
            in_self_refresh <= 1'b0;
            clock_free      <= 1'b0;
            cmd_ready       <= 1'b0;
        end else begin
            dll_enabled     <= dll_en_q;
            dll_locked      <= locked_q;
            in_self_refresh <= in_sr;
            clock_free      <= (state_q == ddsw_pkg::S_SR); // [R15]
            cmd_ready       <= (state_q == ddsw_pkg::S_IDLE);
        end
    end

    // AHB-Lite slave: zero wait states, reads sampled at the address phase.
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    wire         ahb_go = hsel && hready && htrans[1];
    wire  [7:0]  a_off  = {haddr[7:2], 2'b00};
    wire  [31:0] status_w = {25'h000_0000, aborted_q, lat_ok, (state_q == ddsw_pkg::S_IDLE),
                             (state_q == ddsw_pkg::S_SR), in_sr, locked_q, dll_en_q};
    wire  [31:0] rd_mux =
        (haddr[31:8] != 24'h00_0000)     ? 32'h0000_0000 :
        (a_off == ddsw_pkg::REG_STATUS) ? status_w :
        (a_off == ddsw_pkg::REG_TIM0)   ? {t_exit_q, t_hold_q} :
        (a_off == ddsw_pkg::REG_TIM1)   ? {t_lock_q, t_abort_q} :
        (a_off == ddsw_pkg::REG_TIM2)   ? {t_rbusy_q, t_rint_q} :
        (a_off == ddsw_pkg::REG_REFCNT) ? ref_count_q : 32'h0000_0000;

    // Bus phase tracking and read data.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= ahb_go && hwrite && (haddr[31:8] == 24'h00_0000);
            wr_addr_q <= a_off;
            hrdata    <= (ahb_go && !hwrite) ? rd_mux : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Timing registers written in the data phase; each steers a sequencer, lock or refresh counter.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t_hold_q  <= 16'(ddsw_pkg::SR_ENTRY_HOLD_CYC);
            t_exit_q  <= 16'(ddsw_pkg::SR_EXIT_CYC);
            t_abort_q <= 16'(ddsw_pkg::SR_ABORT_CYC);
            t_lock_q  <= 16'(ddsw_pkg::DLL_LOCK_CYC);
            t_rint_q  <= 16'(ddsw_pkg::REF_INTERVAL_CYC);
            t_rbusy_q <= 16'(ddsw_pkg::REF_BUSY_CYC);
        end else if (wr_pend_q) begin
            if (wr_addr_q == ddsw_pkg::REG_TIM0) begin
                t_hold_q <= hwdata[15:0]; // [R23]
                t_exit_q <= hwdata[31:16];
            end
            if (wr_addr_q == ddsw_pkg::REG_TIM1) begin
                t_abort_q <= hwdata[15:0];
                t_lock_q  <= hwdata[31:16];
            end
            if (wr_addr_q == ddsw_pkg::REG_TIM2) begin
                t_rint_q  <= hwdata[15:0];
                t_rbusy_q <= hwdata[31:16];
            end
        end
    end

    // Checks on the sequencing.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_dll_off_write;
        cmd_mrs && p_mr == ddsw_pkg::MR_ONE && !p_addr[ddsw_pkg::DLL_ENABLE_BIT];
    endsequence

    a_dll_off_lock: assert property (s_dll_off_write |=> !dll_en_q && !locked_q) // [R01]
        else $error("DLL still on after disabling write");
    a_dll_on_write: assert property (cmd_mrs && p_mr == ddsw_pkg::MR_ONE
        && p_addr[ddsw_pkg::DLL_ENABLE_BIT] |=> dll_en_q) // [R01]
        else $error("DLL not enabled after enabling write");
    a_abort_no_count: assert property (srx_ok && abort_en_q && ref_active
        |=> $stable(ref_count_q) && !ref_active && aborted_q) // [R07]
        else $error("Aborted refresh was counted");
    a_abort_exit_time: assert property (srx_ok && abort_en_q
        |=> cnt_q == t_abort_q && state_q == ddsw_pkg::S_EXIT) // [R07]
        else $error("Exit wait not loaded with abort delay");
    a_clock_free_hold: assert property (state_q == ddsw_pkg::S_SR_HOLD && !cnt_done
        |=> state_q != ddsw_pkg::S_SR) // [R15]
        else $error("Clock ignored before entry hold elapsed");
    a_clock_free_out: assert property (state_q == ddsw_pkg::S_SR |=> clock_free) // [R15]
        else $error("Clock free flag missing in self refresh");
    a_relock_start: assert property (srx_ok && mr6_new_q && dll_en_q
        |=> !locked_q && lock_cnt_q == t_lock_q) // [R18]
        else $error("No automatic relock at exit");
    a_latency_pair: assert property (!dll_en_q && (rl_code_q != ddsw_pkg::RL_CAS_10_CODE)
        |-> !lat_ok) // [R21]
        else $error("Unsupported latency accepted with DLL off");

endmodule : ddsw_top
`default_nettype wire
